/* File: hdl/module_gpio_port.sv */
`timescale 1ns/1ps
// General-purpose pad port with alarm and overheat alternate functions.
// Assumes firmware reaches it over a plain register port, pads synchronous.
// How it works
// - Each pad: input, output or alternate
// - Input read returns present pad level
// - Output level written and read back
// - Alternate pad driven only internally
// - Pads reset to input, low level
// - Pad 21 sits high during reset
// - Modes offered only where pad supports
// - Pad six alternate is alarm output
// - Alarm rises at start, cleared by command
// - Overheat pad driven high at limit, pad six only (sole alternate pad)
module module_gpio_port
    import gpio_port_pkg::*;
#(
    parameter int unsigned PADS = PAD_COUNT
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic [DATA_WIDTH-1:0] wrData,
    input  wire logic                  wrStrobe,
    input  wire logic                  rdStrobe,
    output logic      [DATA_WIDTH-1:0] rdData,
    input  wire logic [PADS-1:0]       padIn,
    output logic      [PADS-1:0]       padOut,
    output logic      [PADS-1:0]       padOe,
    input  wire logic                  alarmStart,
    input  wire logic                  overTemp
);

    logic [PADS-1:0]   modeWrite;
    logic [PADS-1:0]   levelWrite;
    logic [PADS-1:0]   altLevel;
    logic [PADS-1:0]   outLevel;
    logic [PADS-1:0]   inLevel;
    logic [PADS-1:0]   padReject;
    logic [PADS-1:0]   isInput;
    logic [PADS-1:0]   isOutput;
    pad_mode_t         padMode [PADS];
    pad_mode_t         reqMode;
    logic [REQ_PAD_W-1:0] reqPad;

    logic              alarm;
    logic              next_alarm;
    logic              tempEn;
    logic              next_tempEn;
    logic [REQ_PAD_W-1:0] tempPad;
    logic [REQ_PAD_W-1:0] next_tempPad;
    logic              tempHit;
    logic              next_tempHit;
    logic              rejectFlag;
    logic              next_rejectFlag;
    logic [DATA_WIDTH-1:0] next_rdData;
    logic [MODE_WIDTH*MODE_WORD_PADS-1:0] modeLoWord;
    logic [MODE_WIDTH*MODE_WORD_PADS-1:0] modeHiWord;

    // Decode of register writes
    assign reqPad  = wrData[REQ_PAD_LSB +: REQ_PAD_W];
    assign reqMode = pad_mode_t'(wrData[REQ_MODE_LSB +: MODE_WIDTH]);

    // Per-pad instances with capability and reset level
    generate
        for (genvar i = 0; i < PADS; i++) begin : g_pad
            assign modeWrite[i]  = wrStrobe && (addr == ADDR_MODE_REQ)
                                   && (reqPad == REQ_PAD_W'(i));
            assign levelWrite[i] = wrStrobe && (addr == ADDR_PAD_OUT)
                                   && isOutput[i];
            assign altLevel[i]   = ((i == ALARM_PAD_IDX) && alarm)
                                   || (tempEn && tempHit && (tempPad == REQ_PAD_W'(i)));
            assign isInput[i]    = (padMode[i] == MODE_INPUT);
            assign isOutput[i]   = (padMode[i] == MODE_OUTPUT);
            pad_cell #(
                .RESET_HIGH (RESET_LEVEL[i]),
                .ALT_OK     (ALT_CAPABLE[i])
            ) u_pad (
                .clk        (clk),
                .rst_n      (rst_n),
                .modeWrite  (modeWrite[i]),
                .modeReq    (reqMode),
                .levelWrite (levelWrite[i]),
                .levelReq   (wrData[i]),
                .altLevel   (altLevel[i]),
                .padIn      (padIn[i]),
                .mode       (padMode[i]),
                .outLevel   (outLevel[i]),
                .padOut     (padOut[i]),
                .padOe      (padOe[i]),
                .inLevel    (inLevel[i]),
                .reject     (padReject[i])
            );
        end
    endgenerate

    // Mode readback packing, two bits per pad
    always_comb begin
        modeLoWord = '0;
        modeHiWord = '0;
        for (int k = 0; k < PADS; k++) begin
            if (k < MODE_WORD_PADS) begin
                modeLoWord[MODE_WIDTH*k +: MODE_WIDTH] = padMode[k];
            end else begin
                modeHiWord[MODE_WIDTH*(k-MODE_WORD_PADS) +: MODE_WIDTH] = padMode[k];
            end
        end
    end

    // Alarm, overheat and reject state
    always_comb begin
        next_alarm      = alarm;
        next_tempEn     = tempEn;
        next_tempPad    = tempPad;
        next_tempHit    = tempHit;
        next_rejectFlag = rejectFlag;
        if (wrStrobe && (addr == ADDR_ALARM_CTL) && wrData[ALARM_CLR_BIT]) begin
            next_alarm = 1'b0;
        end
        if (alarmStart) begin
            next_alarm = 1'b1;
        end
        if (wrStrobe && (addr == ADDR_TEMP_CTL)) begin
            next_tempEn  = wrData[TEMP_EN_BIT];
            next_tempPad = wrData[TEMP_PAD_LSB +: REQ_PAD_W];
        end
        next_tempHit = overTemp;
        if (wrStrobe && (addr == ADDR_STATUS) && wrData[STAT_REJECT_BIT]) begin
            next_rejectFlag = 1'b0;
        end
        if ((|padReject) || (wrStrobe && (addr == ADDR_MODE_REQ)
                             && (reqPad >= REQ_PAD_W'(PADS)))) begin
            next_rejectFlag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm      <= 1'b0;
            tempEn     <= 1'b0;
            tempPad    <= '0;
            tempHit    <= 1'b0;
            rejectFlag <= 1'b0;
        end else begin
            alarm      <= next_alarm;
            tempEn     <= next_tempEn;
            tempPad    <= next_tempPad;
            tempHit    <= next_tempHit;
            rejectFlag <= next_rejectFlag;
        end
    end

    // Read mux, data one cycle after strobe
    always_comb begin
        next_rdData = '0;
        if (rdStrobe) begin
            case (addr)
                ADDR_PAD_IN:    next_rdData[PADS-1:0] = inLevel & isInput;
                ADDR_PAD_OUT:   next_rdData[PADS-1:0] = outLevel & isOutput;
                ADDR_MODE_LO:   next_rdData = modeLoWord;
                ADDR_MODE_HI:   next_rdData = modeHiWord;
                ADDR_ALARM_CTL: next_rdData[STAT_ALARM_BIT] = alarm;
                ADDR_TEMP_CTL: begin
                    next_rdData[TEMP_EN_BIT] = tempEn;
                    next_rdData[TEMP_PAD_LSB +: REQ_PAD_W] = tempPad;
                end
                ADDR_STATUS: begin
                    next_rdData[STAT_REJECT_BIT] = rejectFlag;
                    next_rdData[STAT_ALARM_BIT]  = alarm;
                    next_rdData[STAT_TEMP_BIT]   = tempHit;
                end
                ADDR_ALT_CAP:   next_rdData[PADS-1:0] = ALT_CAPABLE[PADS-1:0];
                default:        next_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= next_rdData;
        end
    end

endmodule // module_gpio_port

/* File: common/gpio_port_pkg.sv */
// Constants for the general-purpose pad port: pad count, register map,
// mode codes, per-pad capability and reset levels.
// Assumes a single 10 MHz clock domain and a plain register port.
package gpio_port_pkg;

    localparam int unsigned PAD_COUNT    = 22;
    localparam int unsigned ADDR_WIDTH   = 8;
    localparam int unsigned DATA_WIDTH   = 32;
    localparam int unsigned MODE_WIDTH   = 2;

    // Pad indices, zero based (pad number minus one)
    localparam int unsigned ALARM_PAD_IDX    = 5;
    localparam int unsigned HIGH_RST_PAD_IDX = 20;

    // Register word addresses
    localparam logic [ADDR_WIDTH-1:0] ADDR_PAD_IN     = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PAD_OUT    = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] ADDR_MODE_REQ   = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] ADDR_MODE_LO    = 8'h0c;
    localparam logic [ADDR_WIDTH-1:0] ADDR_MODE_HI    = 8'h10;
    localparam logic [ADDR_WIDTH-1:0] ADDR_ALARM_CTL  = 8'h14;
    localparam logic [ADDR_WIDTH-1:0] ADDR_TEMP_CTL   = 8'h18;
    localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS     = 8'h1c;
    localparam logic [ADDR_WIDTH-1:0] ADDR_ALT_CAP    = 8'h20;

    // Mode request word: pad index in low byte, mode above it
    localparam int unsigned REQ_PAD_LSB  = 0;
    localparam int unsigned REQ_PAD_W    = 5;
    localparam int unsigned REQ_MODE_LSB = 8;

    // Alarm control bits
    localparam int unsigned ALARM_CLR_BIT = 0;
    // Overheat control fields
    localparam int unsigned TEMP_EN_BIT   = 0;
    localparam int unsigned TEMP_PAD_LSB  = 8;
    // Status bits
    localparam int unsigned STAT_REJECT_BIT = 0;
    localparam int unsigned STAT_ALARM_BIT  = 1;
    localparam int unsigned STAT_TEMP_BIT   = 2;

    // Pads per mode-readback word: 16 in the low word, the rest in the high word
    localparam int unsigned MODE_WORD_PADS = 16;

    typedef enum logic [MODE_WIDTH-1:0] {
        MODE_INPUT,
        MODE_OUTPUT,
        MODE_ALT
    } pad_mode_t;

    // Pads able to take the alternate function: pad six only
    localparam logic [PAD_COUNT-1:0] ALT_CAPABLE = 22'h00_0020;
    // Level held during reset and power transition: pad 21 high
    localparam logic [PAD_COUNT-1:0] RESET_LEVEL = 22'h10_0000;

endpackage

/* File: hdl/pad_cell.sv */
`timescale 1ns/1ps
// One pad: mode, output register, driven level and enable.
// Assumes pad input already synchronous to clk.
module pad_cell
    import gpio_port_pkg::*;
#(
    parameter logic RESET_HIGH = 1'b0,
    parameter logic ALT_OK     = 1'b0
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      modeWrite,
    input  wire pad_mode_t modeReq,
    input  wire logic      levelWrite,
    input  wire logic      levelReq,
    input  wire logic      altLevel,
    input  wire logic      padIn,
    output pad_mode_t      mode,
    output logic           outLevel,
    output logic           padOut,
    output logic           padOe,
    output logic           inLevel,
    output logic           reject
);

    pad_mode_t next_mode;
    logic      next_outLevel;
    logic      next_padOut;
    logic      next_padOe;
    logic      next_inLevel;
    logic      modeOk;

    // Capability check and next state
    always_comb begin
        modeOk        = (modeReq == MODE_INPUT) || (modeReq == MODE_OUTPUT)
                        || ((modeReq == MODE_ALT) && ALT_OK);
        reject        = 1'b0;
        next_mode     = mode;
        next_outLevel = outLevel;
        if (modeWrite) begin
            if (modeOk) begin
                next_mode = modeReq;
            end else begin
                reject = 1'b1;
            end
        end
        if (levelWrite) begin
            next_outLevel = levelReq;
        end
        case (next_mode)
            MODE_OUTPUT: begin
                next_padOut = next_outLevel;
                next_padOe  = 1'b1;
            end
            MODE_ALT: begin
                next_padOut = altLevel;
                next_padOe  = 1'b1;
            end
            default: begin
                next_padOut = 1'b0;
                next_padOe  = 1'b0;
            end
        endcase
        next_inLevel = padIn;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode     <= MODE_INPUT;
            outLevel <= 1'b0;
            padOut   <= RESET_HIGH;
            padOe    <= RESET_HIGH;
            inLevel  <= 1'b0;
        end else begin
            mode     <= next_mode;
            outLevel <= next_outLevel;
            padOut   <= next_padOut;
            padOe    <= next_padOe;
            inLevel  <= next_inLevel;
        end
    end

endmodule // pad_cell

/* File: bench/gpio_port_assertions.sv */
// Checker for the pad port, bound to its top module.
// Assumes one clock domain and the plain register port.
`timescale 1ns/1ps
module gpio_port_assertions
    import gpio_port_pkg::*;
#(
    parameter int unsigned PADS = PAD_COUNT
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [DATA_WIDTH-1:0] wrData,
    input wire logic                  wrStrobe,
    input wire logic                  rdStrobe,
    input wire logic [DATA_WIDTH-1:0] rdData,
    input wire logic [PADS-1:0]       padIn,
    input wire logic [PADS-1:0]       padOut,
    input wire logic [PADS-1:0]       padOe,
    input wire logic                  alarmStart,
    input wire logic                  overTemp
);
    logic alt6;
    logic next_alt6;
    logic modeWr;
    // Mode request to an existing pad
    assign modeWr = wrStrobe && addr == ADDR_MODE_REQ && wrData[4:0] < 5'd22;
    // Tracks pad six in alternate mode
    always_comb begin
        next_alt6 = alt6;
        if (modeWr && wrData[4:0] == 5'd5 && wrData[9:8] != 2'd3) begin
            next_alt6 = (wrData[9:8] == 2'd2);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alt6 <= 1'b0;
        end else begin
            alt6 <= next_alt6;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_arm; alt6 && alarmStart; endsequence
    sequence s_up; ##[1:2] padOut[5]; endsequence
    property p_reset_lvl;
        disable iff (1'b0) !rst_n |-> padOe == RESET_LEVEL && padOut == RESET_LEVEL;
    endproperty
    property p_out_en; modeWr && wrData[9:8] == 2'd1 |=> padOe[$past(wrData[4:0])]; endproperty
    property p_in_free; modeWr && wrData[9:8] == 2'd0 |=> !padOe[$past(wrData[4:0])]; endproperty
    property p_alt_six; modeWr && wrData[9:0] == 10'h205 |=> padOe[5]; endproperty
    property p_reject; modeWr && wrData[9] && wrData[4:0] != 5'd5 |=> $stable(padOe); endproperty
    property p_cap; rdStrobe && addr == ADDR_ALT_CAP |=> rdData == 32'h20; endproperty
    property p_alarm_up; s_arm |-> s_up; endproperty
    property p_alarm_hold;
        alt6 && padOut[5] && !wrStrobe && !$past(wrStrobe) && !overTemp && !$past(overTemp)
            && !$past(overTemp, 2) |=> padOut[5];
    endproperty
    a_reset_lvl: assert property (p_reset_lvl) else $error("reset levels wrong");
    a_out_en: assert property (p_out_en) else $error("output pad not driven");
    a_in_free: assert property (p_in_free) else $error("input pad still driven");
    a_alt_six: assert property (p_alt_six) else $error("pad six alternate idle");
    a_reject: assert property (p_reject) else $error("refused mode changed pads");
    a_cap: assert property (p_cap) else $error("capability mask wrong");
    a_alarm_up: assert property (p_alarm_up) else $error("alarm did not rise");
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm fell uncleared");
endmodule // gpio_port_assertions

bind module_gpio_port gpio_port_assertions #(.PADS(PADS)) u_chk (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .alarmStart(alarmStart),
    .overTemp(overTemp));

/* File: bench/pad_partner.sv */
// External device on the pad side; resolves each pad's wire level.
// Assumes the bench sets which pads the device drives.
`timescale 1ns/1ps
module pad_partner
    import gpio_port_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic [PAD_COUNT-1:0] padOut,
    input  wire logic [PAD_COUNT-1:0] padOe,
    input  wire logic [PAD_COUNT-1:0] extLevel,
    input  wire logic [PAD_COUNT-1:0] extOe,
    output logic      [PAD_COUNT-1:0] padLevel
);
    logic [PAD_COUNT-1:0] drift = '0;
    // Undriven pads wander, no pull on them
    always_ff @(posedge clk) drift <= ~drift;
    // Port drive first, then device, else floating
    always_comb padLevel = (padOe & padOut) | (~padOe & ((extOe & extLevel) | (~extOe & drift)));
endmodule // pad_partner

/* File: bench/module_gpio_port_bench.sv */
// Self-checking bench for the pad port with the external device model.
// Assumes the checker binds itself in from its own file.
`timescale 1ns/1ps
module module_gpio_port_bench
    import gpio_port_pkg::*;
;
    logic                  clk = 1'b0, rst_n = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0;
    logic                  alarmStart = 1'b0, overTemp = 1'b0, rdLate = 1'b0;
    logic [ADDR_WIDTH-1:0] addr = '0;
    logic [DATA_WIDTH-1:0] wrData = '0, rdData, v;
    logic [PAD_COUNT-1:0]  padIn, padOut, padOe, extLevel = '0, extOe = '1;
    logic [DATA_WIDTH-1:0] expQ[$];
    int                    bad_count = 0, num_checks = 0, p;
    always #50 clk = ~clk;
    module_gpio_port #(.PADS(PAD_COUNT)) DUT (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .alarmStart(alarmStart),
        .overTemp(overTemp));
    pad_partner u_far (.clk(clk), .padOut(padOut), .padOe(padOe), .extLevel(extLevel),
        .extOe(extOe), .padLevel(padIn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One strobe cycle, released at the next edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wrStrobe <= w;
        rdStrobe <= !w;
        addr <= a;
        wrData <= d;
        @(posedge clk);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, '0);
    endtask
    task automatic lvl(input logic [PAD_COUNT-1:0] eo, input logic [PAD_COUNT-1:0] ep);
        @(negedge clk);
        chk({10'h0, padOe}, {10'h0, eo}, "enable");
        chk({10'h0, padOut & padOe}, {10'h0, ep}, "level");
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Read data stands one cycle after the strobe
    always @(posedge clk) begin
        if (rdLate) begin
            chk(rdData, expQ.pop_front(), "read");
        end
        rdLate <= rdStrobe;
    end
    // Tests take under a hundred cycles
    initial begin
        #(3000 * 100);
        bad_count++;
        close_out();
    end
    initial begin
        // Falling edge at time zero so the pads reset before the first clock
        rst_n <= 1'b0;
        v = $urandom(32'h873b);
        lvl(RESET_LEVEL, RESET_LEVEL);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Pad 21 stays driven until the first edge after release
        @(posedge clk);
        lvl('0, '0);
        rd(ADDR_MODE_LO, '0);
        rd(ADDR_MODE_HI, '0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ADDR_MODE_REQ, 32'h5 | (m << 8));
            rd(ADDR_MODE_LO, 32'((m == 3 ? 2 : m) << 10));
            lvl(m > 0 ? 22'h20 : 22'h0, '0);
        end
        rd(ADDR_STATUS, 32'h1);
        bus(1'b1, ADDR_STATUS, 32'h1);
        $display("test modes done");
        p = $urandom % 22;
        if (p == 5) p = 0;
        v = $urandom;
        extLevel <= PAD_COUNT'($urandom);
        bus(1'b1, ADDR_MODE_REQ, 32'h100 | p);
        // Bit of pad six forced high: the alternate pad must ignore it
        bus(1'b1, ADDR_PAD_OUT, v | 32'h20);
        lvl(22'h20 | (22'h1 << p), v[21:0] & (22'h1 << p));
        rd(ADDR_PAD_OUT, {10'h0, v[21:0] & (22'h1 << p)});
        rd(ADDR_PAD_IN, {10'h0, extLevel & ~(22'h20 | (22'h1 << p))});
        bus(1'b1, ADDR_MODE_REQ, p);
        bus(1'b1, ADDR_MODE_REQ, 32'h200 | p);
        bus(1'b1, ADDR_MODE_REQ, 32'h116);
        lvl(22'h20, '0);
        rd(ADDR_STATUS, 32'h1);
        rd(ADDR_ALT_CAP, 32'h20);
        rd(ADDR_MODE_LO, 32'h800);
        bus(1'b1, ADDR_STATUS, 32'h1);
        $display("test pads done");
        @(posedge clk);
        alarmStart <= 1'b1;
        @(posedge clk);
        alarmStart <= 1'b0;
        repeat (4) @(posedge clk);
        lvl(22'h20, 22'h20);
        rd(ADDR_ALARM_CTL, 32'h2);
        bus(1'b1, ADDR_ALARM_CTL, 32'h1);
        repeat (2) @(posedge clk);
        lvl(22'h20, '0);
        $display("test alarm done");
        bus(1'b1, ADDR_TEMP_CTL, 32'h501);
        overTemp <= 1'b1;
        repeat (3) @(posedge clk);
        lvl(22'h20, 22'h20);
        rd(ADDR_STATUS, 32'h4);
        overTemp <= 1'b0;
        repeat (3) @(posedge clk);
        lvl(22'h20, '0);
        $display("test overheat done");
        close_out();
    end
endmodule // module_gpio_port_bench
